// ### hw/dram_refresh_interval_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - The 8-bit counter advances on each tick of the prescaled clock picked by the 3-bit select.
// - When counter equals period the match flag is set and the counter is cleared to zero.
// - A match while refresh is enabled sends a refresh request to the sequencer.
// - A match while the match interrupt is enabled raises the match interrupt.
// - Equality is checked every cycle, so a match caused by a software write also counts.
// - The counter resets to zero on reset and hardware standby and holds in software standby.
// - The period register is an 8-bit software read and write register setting the interval.
// - The period resets to all ones on reset and hardware standby and holds in software standby.
module dram_refresh_interval_timer #(
  parameter int WIDTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_hw_standby,
  input wire logic i_sw_standby,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_refresh_req,
  output logic o_match_interrupt,
  output logic o_irq
);

  if (WIDTH != 8) begin : g_width_check
    $error("dram_refresh_interval_timer: WIDTH must be 8");
  end

  // ***************************************************
  // Prescaler
  // ***************************************************
  // Select code n ticks every 2^(2n) clocks; code 0 stops the count
  logic [13:0] prescale_ff;
  logic [13:0] prescale_prev_ff;
  logic [7:0] refresh_count_ff;
  logic [7:0] refresh_period_ff;
  logic [7:0] dram_control_reg_ff;
  logic match_flag_ff;
  logic flag_read_one_ff;
  logic [1:0] status_ff;
  logic [1:0] mask_ff;
  logic tick;
  logic match;
  logic run;
  logic [2:0] clock_select;

  assign clock_select = dram_control_reg_ff[refresh_timer_pkg::CTL_CKS_LSB +: 3];
  assign run = !i_sw_standby && !i_hw_standby;

  function automatic logic tap_edge(input logic [2:0] sel, input logic [13:0] cur,
                                    input logic [13:0] prev);
    logic [3:0] idx;
    idx = {sel, 1'b0};
    if (sel == 3'h0) begin
      tap_edge = 1'b0;
    end else begin
      tap_edge = cur[idx - 4'h1] && !prev[idx - 4'h1];
    end
  endfunction

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale_ff <= 14'h0000;
      prescale_prev_ff <= 14'h0000;
    end else if (i_hw_standby) begin
      prescale_ff <= 14'h0000;
      prescale_prev_ff <= 14'h0000;
    end else if (run) begin
      prescale_ff <= prescale_ff + 14'h0001;
      prescale_prev_ff <= prescale_ff;
    end
  end

  assign tick = run && tap_edge(clock_select, prescale_ff, prescale_prev_ff);

  // ***************************************************
  // Compare and count
  // ***************************************************
  assign match = (refresh_count_ff == refresh_period_ff);

  logic wr_count;
  logic wr_period;
  logic wr_control;
  assign wr_count = i_wr && (i_addr == refresh_timer_pkg::ADDR_COUNT);
  assign wr_period = i_wr && (i_addr == refresh_timer_pkg::ADDR_PERIOD);
  assign wr_control = i_wr && (i_addr == refresh_timer_pkg::ADDR_CONTROL);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      refresh_count_ff <= refresh_timer_pkg::COUNT_RESET;
    end else if (i_hw_standby) begin
      refresh_count_ff <= refresh_timer_pkg::COUNT_RESET;
    end else if (wr_count) begin
      refresh_count_ff <= i_wdata;
    end else if (match && !i_sw_standby) begin
      refresh_count_ff <= refresh_timer_pkg::COUNT_RESET;
    end else if (tick) begin
      refresh_count_ff <= refresh_count_ff + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      refresh_period_ff <= refresh_timer_pkg::PERIOD_RESET;
    end else if (i_hw_standby) begin
      refresh_period_ff <= refresh_timer_pkg::PERIOD_RESET;
    end else if (wr_period) begin
      refresh_period_ff <= i_wdata;
    end
  end

  // ***************************************************
  // Control register and match flag
  // ***************************************************
  logic match_evt;
  assign match_evt = match && run && !wr_count;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dram_control_reg_ff <= refresh_timer_pkg::CONTROL_RESET;
    end else if (i_hw_standby) begin
      dram_control_reg_ff <= refresh_timer_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      dram_control_reg_ff <= {1'b0, 2'b00, i_wdata[4:0]};
    end
  end

  // Clearing needs a prior read as 1, so a stale write of 0 cannot lose a match
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      match_flag_ff <= 1'b0;
      flag_read_one_ff <= 1'b0;
    end else if (i_hw_standby) begin
      match_flag_ff <= 1'b0;
      flag_read_one_ff <= 1'b0;
    end else begin
      if (match_evt) begin
        match_flag_ff <= 1'b1;
      end else if (wr_control && !i_wdata[refresh_timer_pkg::CTL_FLAG_POS]
                   && flag_read_one_ff) begin
        match_flag_ff <= 1'b0;
      end
      if (i_rd && (i_addr == refresh_timer_pkg::ADDR_CONTROL) && match_flag_ff) begin
        flag_read_one_ff <= 1'b1;
      end else if (wr_control || !match_flag_ff) begin
        flag_read_one_ff <= 1'b0;
      end
    end
  end

  // ***************************************************
  // Refresh request and match interrupt
  // ***************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_refresh_req <= 1'b0;
    end else begin
      o_refresh_req <= match_evt && dram_control_reg_ff[refresh_timer_pkg::CTL_REFRESH_ENABLE_POS];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_match_interrupt <= 1'b0;
    end else begin
      o_match_interrupt <= match_flag_ff && dram_control_reg_ff[refresh_timer_pkg::CTL_MATCH_IRQ_ENABLE_POS];
    end
  end

  // ***************************************************
  // Sticky status: bit0 match, bit1 refresh issued
  // ***************************************************
  logic rd_status;
  logic [1:0] events;
  assign rd_status = i_rd && (i_addr == refresh_timer_pkg::ADDR_STATUS);
  assign events = {match_evt && dram_control_reg_ff[refresh_timer_pkg::CTL_REFRESH_ENABLE_POS], match_evt};

  // An event in the clearing read cycle survives the clear
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status_ff <= 2'b00;
    end else if (rd_status) begin
      status_ff <= events;
    end else begin
      status_ff <= status_ff | events;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_ff <= refresh_timer_pkg::MASK_RESET[1:0];
    end else if (i_wr && (i_addr == refresh_timer_pkg::ADDR_MASK)) begin
      mask_ff <= i_wdata[1:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((rd_status ? 2'b00 : status_ff) | events) & mask_ff);
    end
  end

  // ***************************************************
  // Read port
  // ***************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else if (i_addr == refresh_timer_pkg::ADDR_COUNT) begin
      o_rdata <= refresh_count_ff;
    end else if (i_addr == refresh_timer_pkg::ADDR_PERIOD) begin
      o_rdata <= refresh_period_ff;
    end else if (i_addr == refresh_timer_pkg::ADDR_CONTROL) begin
      o_rdata <= {match_flag_ff, dram_control_reg_ff[6:0]};
    end else if (i_addr == refresh_timer_pkg::ADDR_STATUS) begin
      o_rdata <= {6'h00, status_ff};
    end else if (i_addr == refresh_timer_pkg::ADDR_MASK) begin
      o_rdata <= {6'h00, mask_ff};
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  property p_match_clears;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (match_evt && !i_hw_standby) |=> (refresh_count_ff == 8'h00) && match_flag_ff;
  endproperty
  a_match_clears: assert property (p_match_clears) else $error("match did not clear count");

  property p_refresh;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (match_evt && dram_control_reg_ff[3]) |=> o_refresh_req;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh request missing");

  property p_no_refresh;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_refresh_req |-> $past(match_evt) && $past(dram_control_reg_ff[3]);
  endproperty
  a_no_refresh: assert property (p_no_refresh) else $error("spurious refresh");

  property p_tick;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (tick && !match && !wr_count && !i_hw_standby) |=>
      refresh_count_ff == $past(refresh_count_ff) + 8'h01;
  endproperty
  a_tick: assert property (p_tick) else $error("count did not advance");

  property p_hold_sw;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_sw_standby && !i_hw_standby && !i_wr) |=> $stable(refresh_count_ff)
      && $stable(refresh_period_ff);
  endproperty
  a_hold_sw: assert property (p_hold_sw) else $error("standby lost state");

  property p_hw_stby;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    i_hw_standby |=> refresh_count_ff == 8'h00 && refresh_period_ff == 8'hff;
  endproperty
  a_hw_stby: assert property (p_hw_stby) else $error("hw standby init wrong");

  property p_period_wr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_period && !i_hw_standby) |=> refresh_period_ff == $past(i_wdata);
  endproperty
  a_period_wr: assert property (p_period_wr) else $error("period write lost");

  property p_flag_sticky;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (match_flag_ff && !flag_read_one_ff && !i_hw_standby) |=> match_flag_ff;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

  property p_match_int;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_match_interrupt == ($past(match_flag_ff)
      && $past(dram_control_reg_ff[refresh_timer_pkg::CTL_MATCH_IRQ_ENABLE_POS]));
  endproperty
  a_match_int: assert property (p_match_int) else $error("match interrupt wrong");

  property p_count_wr;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_count && !i_hw_standby) |=> refresh_count_ff == $past(i_wdata);
  endproperty
  a_count_wr: assert property (p_count_wr) else $error("count write lost");

  property p_rdata_idle;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

endmodule // dram_refresh_interval_timer
`default_nettype wire

// ### hw/refresh_timer_pkg.sv
package refresh_timer_pkg;
  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [3:0] ADDR_COUNT = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  // ***************************************************
  // Control register fields
  // ***************************************************
  localparam int CTL_CKS_LSB = 0;
  localparam int CTL_REFRESH_ENABLE_POS = 3;
  localparam int CTL_MATCH_IRQ_ENABLE_POS = 4;
  localparam int CTL_FLAG_POS = 7;
  // ***************************************************
  // Reset values
  // ***************************************************
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
endpackage

// ### verification/refresh_sink.sv
`timescale 1ns/10ps
`default_nettype none
// ***************************************************
// Refresh sequencer stand-in: counts refresh requests
// ***************************************************
module refresh_sink (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_refresh_req,
  output var int o_refresh_cnt
);
  // One pulse is one refresh cycle, so a stretched pulse shows up as extra refreshes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_refresh_cnt <= 0;
    end else if (i_refresh_req) begin
      o_refresh_cnt <= o_refresh_cnt + 1;
    end
  end
endmodule // refresh_sink
`default_nettype wire

// ### verification/tb_dram_refresh_interval_timer.sv
`timescale 1ns/10ps
`default_nettype none
module tb_dram_refresh_interval_timer;
  logic sys_clk, rst_n, hw_sb, sw_sb, wr_s, rd_s, en;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d, v, c1, ctl;
  logic refresh_req, match_int, irq;
  int pulses, base, error_cnt, comparisons;

  dram_refresh_interval_timer DUT (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_hw_standby(hw_sb),
    .i_sw_standby(sw_sb), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
    .o_rdata(rdata), .o_refresh_req(refresh_req), .o_match_interrupt(match_int), .o_irq(irq));
  refresh_sink u_sink (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_refresh_req(refresh_req),
    .o_refresh_cnt(pulses));

  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;
  // ***************************************************
  // Checking and bus tasks
  // ***************************************************
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  // Prescaler phase is free running, so tick counts may be off by the tolerance
  task automatic chki(input string n, input int e, input int g, input int tol);
    comparisons++;
    if (g < e - tol || g > e + tol) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
    end
  endtask
  function automatic int exp_pulses(input int cyc, input int sel, input int per);
    return cyc / (per << (2 * sel));
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    addr <= a;
    wdata <= x;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] x);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    #1 x = rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string n);
    logic [7:0] x;
    rd(a, x);
    chk8(n, e, x);
  endtask
  // ***************************************************
  // Scenarios
  // ***************************************************
  initial begin
    rst_n = 1'b0; hw_sb = 1'b0; sw_sb = 1'b0; wr_s = 1'b0; rd_s = 1'b0;
    addr = 4'h0; wdata = 8'h00; error_cnt = 0; comparisons = 0;
    void'($urandom(32'h6bbb2c6d));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rchk(refresh_timer_pkg::ADDR_COUNT, refresh_timer_pkg::COUNT_RESET, "count");
    rchk(refresh_timer_pkg::ADDR_PERIOD, refresh_timer_pkg::PERIOD_RESET, "period");
    rchk(refresh_timer_pkg::ADDR_CONTROL, refresh_timer_pkg::CONTROL_RESET, "control");
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom_range(254, 1));
      en = i[0];
      ctl = (8'h01 << refresh_timer_pkg::CTL_MATCH_IRQ_ENABLE_POS) | (8'(en) << refresh_timer_pkg::CTL_REFRESH_ENABLE_POS);
      wr(refresh_timer_pkg::ADDR_PERIOD, d);
      rchk(refresh_timer_pkg::ADDR_PERIOD, d, "period rw");
      wr(refresh_timer_pkg::ADDR_CONTROL, ctl);
      base = pulses;
      // Counter stopped, so only the software write can make the match
      wr(refresh_timer_pkg::ADDR_COUNT, d);
      @(posedge sys_clk);
      #1 chk1("refresh req", en, refresh_req);
      @(posedge sys_clk);
      #1 chk1("match int", 1'b1, match_int);
      chki("pulses", base + int'(en), pulses, 0);
      rchk(refresh_timer_pkg::ADDR_COUNT, 8'h00, "count clr");
      rd(refresh_timer_pkg::ADDR_CONTROL, v);
      chk1("flag", 1'b1, v[refresh_timer_pkg::CTL_FLAG_POS]);
      wr(refresh_timer_pkg::ADDR_CONTROL, ctl);
      rd(refresh_timer_pkg::ADDR_CONTROL, v);
      chk1("flag clr", 1'b0, v[refresh_timer_pkg::CTL_FLAG_POS]);
      chk1("match int clr", 1'b0, match_int);
    end
    rchk(refresh_timer_pkg::ADDR_STATUS, 8'h03, "status");
    rchk(refresh_timer_pkg::ADDR_STATUS, 8'h00, "status clr");
    repeat (2) @(posedge sys_clk);
    #1 chk1("irq", 1'b0, irq);
    wr(refresh_timer_pkg::ADDR_MASK, 8'h01);
    rchk(refresh_timer_pkg::ADDR_MASK, 8'h01, "mask");
    // Same count again forces one more match, which the unmasked status bit must report
    wr(refresh_timer_pkg::ADDR_COUNT, d);
    repeat (2) @(posedge sys_clk);
    #1 chk1("irq set", 1'b1, irq);
    rchk(refresh_timer_pkg::ADDR_STATUS, 8'h03, "status irq");
    repeat (2) @(posedge sys_clk);
    #1 chk1("irq clr", 1'b0, irq);
    wr(refresh_timer_pkg::ADDR_PERIOD, 8'h03);
    for (int s = 1; s < 3; s++) begin
      wr(refresh_timer_pkg::ADDR_CONTROL, 8'(s) | (8'h01 << refresh_timer_pkg::CTL_REFRESH_ENABLE_POS));
      base = pulses;
      repeat (480) @(posedge sys_clk);
      chki("tick pulses", base + exp_pulses(480, s, 3), pulses, 1);
    end
    sw_sb <= 1'b1;
    repeat (2) @(posedge sys_clk);
    base = pulses;
    rd(refresh_timer_pkg::ADDR_COUNT, c1);
    repeat (100) @(posedge sys_clk);
    rchk(refresh_timer_pkg::ADDR_COUNT, c1, "frozen count");
    chki("standby pulses", base, pulses, 0);
    rchk(refresh_timer_pkg::ADDR_PERIOD, 8'h03, "kept period");
    sw_sb <= 1'b0;
    @(posedge sys_clk);
    hw_sb <= 1'b1;
    @(posedge sys_clk);
    hw_sb <= 1'b0;
    rchk(refresh_timer_pkg::ADDR_COUNT, refresh_timer_pkg::COUNT_RESET, "hw count");
    rchk(refresh_timer_pkg::ADDR_PERIOD, refresh_timer_pkg::PERIOD_RESET, "hw period");
    rchk(refresh_timer_pkg::ADDR_CONTROL, refresh_timer_pkg::CONTROL_RESET, "hw control");
    wrap_up();
  end

  // Whole run is near 1200 cycles; a hang beyond this is a failure
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end
endmodule // tb_dram_refresh_interval_timer
`default_nettype wire
